/* File: pad_mux_pkg.sv */
// Shared constants, address map and decode helpers for the pad multiplexer.
// Assumes both ends run on one clock and meet through pad_mux_if.
package pad_mux_pkg;

  // Pad space: ten ports of sixteen pads, index = port * 16 + bit.
  localparam int NUM_PADS  = 160;
  localparam int NUM_PORTS = 10;
  localparam int PORT_W    = 16;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 16;
  localparam logic [7:0] PAD_LIMIT  = 8'(NUM_PADS);
  localparam logic [3:0] PORT_LIMIT = 4'(NUM_PORTS);

  // Pad configuration register layout.
  localparam int CFG_W    = 8;
  localparam int SEL_LSB  = 0;
  localparam int SEL_W    = 4;
  localparam int OBE_BIT  = 4;
  localparam int IBE_BIT  = 5;
  localparam int APC_BIT  = 6;
  localparam int LINK_BIT = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  // Function and input select codes.
  localparam logic [3:0] CODE_GPIO    = 4'h0;
  localparam logic [3:0] CODE_ALT1    = 4'h1;
  localparam logic [3:0] CODE_ALT2    = 4'h2;
  localparam logic [3:0] CODE_DISABLE = 4'h0;
  localparam logic [3:0] SEL_RESET    = 4'h0;

  // Address regions selected by addr[9:8].
  localparam logic [1:0] REGION_CFG  = 2'h0;
  localparam logic [1:0] REGION_SEL  = 2'h1;
  localparam logic [1:0] REGION_PORT = 2'h2;

  // Pad indices that the routing refers to.
  localparam logic [7:0] PAD_A0  = 8'h00;
  localparam logic [7:0] PAD_A2  = 8'h02;
  localparam logic [7:0] PAD_A3  = 8'h03;
  localparam logic [7:0] PAD_A8  = 8'h08;
  localparam logic [7:0] PAD_A10 = 8'h0A;
  localparam logic [7:0] PAD_A11 = 8'h0B;
  localparam logic [7:0] PAD_A13 = 8'h0D;
  localparam logic [7:0] PAD_A15 = 8'h0F;
  localparam logic [7:0] PAD_B1  = 8'h11;
  localparam logic [7:0] PAD_C7  = 8'h27;
  localparam logic [7:0] PAD_C13 = 8'h2D;
  localparam logic [7:0] PAD_C15 = 8'h2F;
  localparam logic [7:0] PAD_D7  = 8'h37;
  localparam logic [7:0] PAD_D14 = 8'h3E;
  localparam logic [7:0] PAD_E15 = 8'h4F;
  localparam logic [7:0] PAD_F15 = 8'h5F;
  localparam logic [7:0] PAD_I6  = 8'h86;
  localparam logic [7:0] PAD_J1  = 8'h91;
  localparam logic [7:0] PAD_J4  = 8'h94;
  localparam logic [7:0] PAD_J8  = 8'h98;
  localparam logic [7:0] PAD_J9  = 8'h99;

  // Destination inputs and the input select register number of each.
  localparam int NUM_DEST = 14;
  localparam int DEST_CAN0_RX     = 0;
  localparam int DEST_CAN1_RX     = 1;
  localparam int DEST_CAN2_RX     = 2;
  localparam int DEST_TRIG0       = 3;
  localparam int DEST_TRIG1       = 4;
  localparam int DEST_SER0_DATA   = 5;
  localparam int DEST_SER1_DATA   = 6;
  localparam int DEST_SER2_DATA   = 7;
  localparam int DEST_SER2_CLK    = 8;
  localparam int DEST_SER2_SEL0   = 9;
  localparam int DEST_SER3_DATA   = 10;
  localparam int DEST_TIMER_TWO   = 11;
  localparam int DEST_TIMER_FOUR  = 12;
  localparam int DEST_TIMER_FIVE  = 13;
  localparam int DEST_MII_BIT3    = 14;
  localparam logic [7:0] SELREG_CAN0  = 8'h20;
  localparam logic [7:0] SELREG_CAN1  = 8'h21;
  localparam logic [7:0] SELREG_CAN2  = 8'h22;
  localparam logic [7:0] SELREG_TRIG0 = 8'h26;
  localparam logic [7:0] SELREG_TRIG1 = 8'h27;
  localparam logic [7:0] SELREG_SER0D = 8'h29;
  localparam logic [7:0] SELREG_SER1D = 8'h2C;
  localparam logic [7:0] SELREG_SER2D = 8'h2F;
  localparam logic [7:0] SELREG_SER2C = 8'h30;
  localparam logic [7:0] SELREG_SER2S = 8'h31;
  localparam logic [7:0] SELREG_SER3D = 8'h32;
  localparam logic [7:0] SELREG_TMR2  = 8'h49;
  localparam logic [7:0] SELREG_TMR4  = 8'h4B;
  localparam logic [7:0] SELREG_TMR5  = 8'h4C;
  localparam logic [7:0] SELREG_MII3  = 8'hE5;

  // True for pads that exist; absent pads have no registers at all.
  function automatic logic pad_implemented(input logic [7:0] idx);
    logic [3:0] p;
    logic [3:0] b;
    p = idx[7:4];
    b = idx[3:0];
    case (p)
      4'h0, 4'h1, 4'h8: return 1'b1;
      4'h2: return !(b == 4'h3 || b == 4'h8 || b == 4'h9);
      4'h3: return !(b == 4'hD || b == 4'hF);
      4'h4: return !(b == 4'h1 || b == 4'h3 || b == 4'h8);
      4'h5: return !(b == 4'h1 || b == 4'h2);
      4'h6: return !(b <= 4'h1 || b >= 4'hC);
      4'h7: return b > 4'h3;
      4'h9: return b < 4'hA;
      default: return 1'b0;
    endcase
  endfunction

  // Bit mask of implemented pads within one port.
  function automatic logic [PORT_W-1:0] port_mask(input logic [3:0] port);
    logic [PORT_W-1:0] m;
    m = '0;
    for (int b = 0; b < PORT_W; b++) begin
      m[b] = pad_implemented({port, 4'(b)});
    end
    return m;
  endfunction

endpackage

/* File: pad_mux_if.sv */
// Register access link between the configuring master and the pad multiplexer.
// Assumes both ends share clk_i and sys_rst_i; the testbench ties them together.
`timescale 1ns/1ps
interface pad_mux_if;
  logic                              req;
  logic                              we;
  logic [pad_mux_pkg::ADDR_W-1:0]    addr;
  logic [pad_mux_pkg::DATA_W-1:0]    wdata;
  logic                              ack;
  logic                              err;
  logic [pad_mux_pkg::DATA_W-1:0]    rdata;

  modport host (output req, output we, output addr, output wdata, input ack, input err, input rdata);
  modport device (input req, input we, input addr, input wdata, output ack, output err, output rdata);
endinterface

/* File: pad_mux_device.sv */
// Pad multiplexer: per-pad configuration registers and per-destination input selects.
// Assumes pad inputs are asynchronous and a master on pad_mux_if holds req until ack.
`timescale 1ns/1ps
module pad_mux_device (
  input  wire logic                                clk_i,
  input  wire logic                                sys_rst_i,
  pad_mux_if.device                                bus,
  input  wire logic [pad_mux_pkg::NUM_PADS-1:0]    pad_in_i,
  input  wire logic [pad_mux_pkg::NUM_PADS-1:0]    gpio_out_i,
  input  wire logic [pad_mux_pkg::NUM_PADS-1:0]    alt1_out_i,
  input  wire logic                                timer_chan_two_out_i,
  input  wire logic                                timer_chan_four_out_i,
  input  wire logic                                timer_chan_five_out_i,
  input  wire logic                                trace_ready_n_i,
  input  wire logic                                adc_enable_i,
  output logic      [pad_mux_pkg::NUM_PADS-1:0]    pad_out_o,
  output logic      [pad_mux_pkg::NUM_PADS-1:0]    pad_oe_o,
  output logic      [pad_mux_pkg::NUM_PADS-1:0]    pad_ie_o,
  output logic      [pad_mux_pkg::NUM_PADS-1:0]    analog_en_o,
  output logic      [pad_mux_pkg::NUM_PADS-1:0]    link_sel_o,
  output logic      [pad_mux_pkg::NUM_DEST:0]      dest_in_o
);

  // Highest legal function code of a pad; codes above it are reserved.
  function automatic logic [3:0] max_code(input logic [7:0] idx);
    if (idx == pad_mux_pkg::PAD_J8 || idx == pad_mux_pkg::PAD_J9) begin
      return pad_mux_pkg::CODE_ALT2;
    end
    return pad_mux_pkg::CODE_ALT1;
  endfunction

  // Maps an input select register number to {valid, destination}.
  function automatic logic [4:0] selreg_dest(input logic [7:0] n);
    case (n)
      pad_mux_pkg::SELREG_CAN0:  return {1'b1, 4'(pad_mux_pkg::DEST_CAN0_RX)};
      pad_mux_pkg::SELREG_CAN1:  return {1'b1, 4'(pad_mux_pkg::DEST_CAN1_RX)};
      pad_mux_pkg::SELREG_CAN2:  return {1'b1, 4'(pad_mux_pkg::DEST_CAN2_RX)};
      pad_mux_pkg::SELREG_TRIG0: return {1'b1, 4'(pad_mux_pkg::DEST_TRIG0)};
      pad_mux_pkg::SELREG_TRIG1: return {1'b1, 4'(pad_mux_pkg::DEST_TRIG1)};
      pad_mux_pkg::SELREG_SER0D: return {1'b1, 4'(pad_mux_pkg::DEST_SER0_DATA)};
      pad_mux_pkg::SELREG_SER1D: return {1'b1, 4'(pad_mux_pkg::DEST_SER1_DATA)};
      pad_mux_pkg::SELREG_SER2D: return {1'b1, 4'(pad_mux_pkg::DEST_SER2_DATA)};
      pad_mux_pkg::SELREG_SER2C: return {1'b1, 4'(pad_mux_pkg::DEST_SER2_CLK)};
      pad_mux_pkg::SELREG_SER2S: return {1'b1, 4'(pad_mux_pkg::DEST_SER2_SEL0)};
      pad_mux_pkg::SELREG_SER3D: return {1'b1, 4'(pad_mux_pkg::DEST_SER3_DATA)};
      pad_mux_pkg::SELREG_TMR2:  return {1'b1, 4'(pad_mux_pkg::DEST_TIMER_TWO)};
      pad_mux_pkg::SELREG_TMR4:  return {1'b1, 4'(pad_mux_pkg::DEST_TIMER_FOUR)};
      pad_mux_pkg::SELREG_TMR5:  return {1'b1, 4'(pad_mux_pkg::DEST_TIMER_FIVE)};
      pad_mux_pkg::SELREG_MII3:  return {1'b1, 4'(pad_mux_pkg::DEST_MII_BIT3)};
      default:                   return 5'h00;
    endcase
  endfunction

  // Maps a destination and its select code to {valid, pad index}; unlisted codes are reserved.
  function automatic logic [8:0] dest_src(input int d, input logic [3:0] c);
    logic [7:0] p;
    logic       v;
    p = 8'h00;
    v = 1'b1;
    case (d)
      pad_mux_pkg::DEST_CAN0_RX, pad_mux_pkg::DEST_CAN1_RX: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_A15;
        else if (c == 4'h2) p = pad_mux_pkg::PAD_B1;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_CAN2_RX: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_F15;
        else if (c == 4'h2) p = pad_mux_pkg::PAD_I6;
        else if (c == 4'h3) p = pad_mux_pkg::PAD_J8;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_TRIG0: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_C13;
        else if (c == 4'h2) p = pad_mux_pkg::PAD_C15;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_TRIG1: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_J4;
        else if (c == 4'h2) p = pad_mux_pkg::PAD_J9;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_SER0_DATA: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_C7;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_SER1_DATA: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_A8;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_SER2_DATA: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_A13;
        else if (c == 4'h2) p = pad_mux_pkg::PAD_A2;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_SER2_CLK: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_A0;
        else if (c == 4'h2) p = pad_mux_pkg::PAD_A11;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_SER2_SEL0: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_A3;
        else if (c == 4'h2) p = pad_mux_pkg::PAD_A10;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_SER3_DATA: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_J1;
        else if (c == 4'h2) p = pad_mux_pkg::PAD_D7;
        else if (c == 4'h3) p = pad_mux_pkg::PAD_D14;
        else if (c == 4'h4) p = pad_mux_pkg::PAD_E15;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_TIMER_TWO, pad_mux_pkg::DEST_TIMER_FOUR: begin
        if (c == 4'h4) p = pad_mux_pkg::PAD_J8;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_TIMER_FIVE: begin
        if (c == 4'h4) p = pad_mux_pkg::PAD_J9;
        else v = 1'b0;
      end
      pad_mux_pkg::DEST_MII_BIT3: begin
        if (c == 4'h1) p = pad_mux_pkg::PAD_J9;
        else v = 1'b0;
      end
      default: v = 1'b0;
    endcase
    return {v, p};
  endfunction

  logic [pad_mux_pkg::CFG_W-1:0]    cfg_q [pad_mux_pkg::NUM_PADS];
  logic [pad_mux_pkg::SEL_W-1:0]    sel_q [pad_mux_pkg::NUM_DEST+1];
  logic [pad_mux_pkg::NUM_PADS-1:0] pad_meta_q;
  logic [pad_mux_pkg::NUM_PADS-1:0] pad_sync_q;
  logic                             ack_q;
  logic                             err_q;
  logic [pad_mux_pkg::DATA_W-1:0]   rdata_q;

  // Address decode of the current request.
  wire logic [1:0] region   = bus.addr[9:8];
  wire logic [7:0] offset   = bus.addr[7:0];
  wire logic [4:0] sel_dec  = selreg_dest(offset);
  wire logic [3:0] sel_idx  = sel_dec[3:0];
  wire logic       take     = bus.req && !ack_q;
  wire logic       hit_cfg  = region == pad_mux_pkg::REGION_CFG && offset < pad_mux_pkg::PAD_LIMIT &&
                              pad_mux_pkg::pad_implemented(offset);
  wire logic       hit_sel  = region == pad_mux_pkg::REGION_SEL && sel_dec[4];
  wire logic       hit_port = region == pad_mux_pkg::REGION_PORT && offset[7:4] == 4'h0 &&
                              offset[3:0] < pad_mux_pkg::PORT_LIMIT;
  wire logic       hit_any  = hit_cfg || hit_sel || hit_port;
  wire logic [pad_mux_pkg::DATA_W-1:0] port_data =
    pad_sync_q[{offset[3:0], 4'h0} +: pad_mux_pkg::PORT_W];
  wire logic [pad_mux_pkg::DATA_W-1:0] rd_mux =
    hit_cfg ? pad_mux_pkg::DATA_W'(cfg_q[offset]) :
    hit_sel ? pad_mux_pkg::DATA_W'(sel_q[sel_idx]) :
    hit_port ? port_data : '0;

  // Bus answer: one cycle after a request is seen, error for anything unmapped.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= take;
      err_q   <= take && !hit_any;
      rdata_q <= (take && !bus.we) ? rd_mux : '0;
    end
  end

  assign bus.ack   = ack_q;
  assign bus.err   = err_q;
  assign bus.rdata = rdata_q;

  // Register storage; only implemented pads and listed destinations accept writes.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < pad_mux_pkg::NUM_PADS; i++) cfg_q[i] <= pad_mux_pkg::CFG_RESET;
      for (int d = 0; d <= pad_mux_pkg::NUM_DEST; d++) sel_q[d] <= pad_mux_pkg::SEL_RESET;
    end else if (take && bus.we) begin
      if (hit_cfg) cfg_q[offset] <= bus.wdata[pad_mux_pkg::CFG_W-1:0];
      if (hit_sel) sel_q[sel_idx] <= bus.wdata[pad_mux_pkg::SEL_W-1:0];
    end
  end

  // Pad inputs are asynchronous and pass two flip-flops first.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pad_meta_q <= '0;
      pad_sync_q <= '0;
    end else begin
      pad_meta_q <= pad_in_i;
      pad_sync_q <= pad_meta_q;
    end
  end

  // Per-pad output selection and buffer enables.
  for (genvar i = 0; i < pad_mux_pkg::NUM_PADS; i++) begin : g_pad
    wire logic [3:0] code  = cfg_q[i][pad_mux_pkg::SEL_LSB +: pad_mux_pkg::SEL_W];
    wire logic       link  = cfg_q[i][pad_mux_pkg::LINK_BIT] && pad_mux_pkg::pad_implemented(8'(i));
    wire logic       nul   = code > max_code(8'(i)) || !pad_mux_pkg::pad_implemented(8'(i));
    wire logic       act   = !nul && !link;
    wire logic       j9    = 8'(i) == pad_mux_pkg::PAD_J9;
    wire logic       j8    = 8'(i) == pad_mux_pkg::PAD_J8;
    wire logic       alt2v = j9 ? trace_ready_n_i : timer_chan_two_out_i;
    wire logic       alt1v = j9 ? timer_chan_five_out_i : j8 ? timer_chan_four_out_i : alt1_out_i[i];
    wire logic       out_d = code == pad_mux_pkg::CODE_GPIO ? gpio_out_i[i] :
                             code == pad_mux_pkg::CODE_ALT1 ? alt1v : alt2v;

    // Registered pad controls; a null or link pad drives nothing and has its input buffer off; only a link pad also loses its analog enable.
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        pad_out_o[i]   <= 1'b0;
        pad_oe_o[i]    <= 1'b0;
        pad_ie_o[i]    <= 1'b0;
        analog_en_o[i] <= 1'b0;
        link_sel_o[i]  <= 1'b0;
      end else begin
        pad_out_o[i]   <= act && out_d;
        pad_oe_o[i]    <= act && cfg_q[i][pad_mux_pkg::OBE_BIT];
        pad_ie_o[i]    <= act && cfg_q[i][pad_mux_pkg::IBE_BIT];
        analog_en_o[i] <= !link && cfg_q[i][pad_mux_pkg::APC_BIT] && adc_enable_i;
        link_sel_o[i]  <= link;
      end
    end
  end

  // Destination routing; a disabled or reserved code holds the input low.
  for (genvar d = 0; d <= pad_mux_pkg::NUM_DEST; d++) begin : g_dest
    wire logic [8:0] src = dest_src(d, sel_q[d]);
    wire logic       val = src[8] && pad_sync_q[src[7:0]] && pad_ie_o[src[7:0]];

    // Registered destination input.
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        dest_in_o[d] <= 1'b0;
      end else begin
        dest_in_o[d] <= val;
      end
    end
  end

endmodule

/* File: pad_mux_host.sv */
// Configuring master: turns user commands into single register transfers on pad_mux_if.
// Assumes the device answers every request with ack, one request outstanding at a time.
`timescale 1ns/1ps
module pad_mux_host (
  input  wire logic                              clk_i,
  input  wire logic                              sys_rst_i,
  pad_mux_if.host                                bus,
  input  wire logic                              cmd_valid_i,
  input  wire logic                              cmd_write_i,
  input  wire logic [pad_mux_pkg::ADDR_W-1:0]    cmd_addr_i,
  input  wire logic [pad_mux_pkg::DATA_W-1:0]    cmd_wdata_i,
  output logic                                   cmd_ready_o,
  output logic                                   rsp_valid_o,
  output logic                                   rsp_err_o,
  output logic      [pad_mux_pkg::DATA_W-1:0]    rsp_rdata_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } host_state_t;

  host_state_t                      state_q;
  logic                             req_q;
  logic                             we_q;
  logic [pad_mux_pkg::ADDR_W-1:0]   addr_q;
  logic [pad_mux_pkg::DATA_W-1:0]   wdata_q;

  // A link-selected pad configuration is sent with output and input buffer enables and function cleared; the analog bit is kept.
  wire logic cmd_cfg  = cmd_addr_i[9:8] == pad_mux_pkg::REGION_CFG;
  wire logic cmd_link = cmd_write_i && cmd_cfg && cmd_wdata_i[pad_mux_pkg::LINK_BIT];
  wire logic [pad_mux_pkg::DATA_W-1:0] link_clear =
    pad_mux_pkg::DATA_W'((1 << pad_mux_pkg::OBE_BIT) | (1 << pad_mux_pkg::IBE_BIT) |
                         (((1 << pad_mux_pkg::SEL_W) - 1) << pad_mux_pkg::SEL_LSB));
  wire logic [pad_mux_pkg::DATA_W-1:0] wdata_d = cmd_link ? (cmd_wdata_i & ~link_clear) : cmd_wdata_i;
  wire logic       accept   = state_q == ST_IDLE && cmd_ready_o && cmd_valid_i;
  wire logic       port_rd  = addr_q[9:8] == pad_mux_pkg::REGION_PORT && !we_q;
  wire logic [pad_mux_pkg::DATA_W-1:0] rd_masked =
    port_rd ? (bus.rdata & pad_mux_pkg::port_mask(addr_q[3:0])) : bus.rdata;

  // Request sequencing: hold req until ack, then report one response pulse.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q     <= ST_IDLE;
      req_q       <= 1'b0;
      we_q        <= 1'b0;
      addr_q      <= '0;
      wdata_q     <= '0;
      cmd_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_err_o   <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (accept) begin
            state_q     <= ST_BUSY;
            req_q       <= 1'b1;
            we_q        <= cmd_write_i;
            addr_q      <= cmd_addr_i;
            wdata_q     <= wdata_d;
            cmd_ready_o <= 1'b0;
          end
        end
        ST_BUSY: begin
          if (bus.ack) begin
            state_q     <= ST_IDLE;
            req_q       <= 1'b0;
            cmd_ready_o <= 1'b1;
            rsp_valid_o <= 1'b1;
            rsp_err_o   <= bus.err;
            rsp_rdata_o <= rd_masked;
          end
        end
      endcase
    end
  end

  assign bus.req   = req_q;
  assign bus.we    = we_q;
  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;

endmodule

/* File: pad_mux_sva.sv */
// Checker for the register link between the configuring master and the pad multiplexer.
// Assumes it is instantiated beside pad_mux_if and sees its signals as plain inputs.
`timescale 1ns/1ps
module pad_mux_sva (
  input wire logic                           clk_i,
  input wire logic                           sys_rst_i,
  input wire logic                           req,
  input wire logic                           we,
  input wire logic [pad_mux_pkg::ADDR_W-1:0] addr,
  input wire logic [pad_mux_pkg::DATA_W-1:0] wdata,
  input wire logic                           ack,
  input wire logic                           err,
  input wire logic [pad_mux_pkg::DATA_W-1:0] rdata
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // A request is taken when it is up and no answer is standing; absent pads have no register.
  wire logic take_w = req && !ack;
  wire logic cfg_w  = addr[9:8] == 2'h0;
  wire logic gone_w = (addr[7:4] == 4'h7 && addr[3:0] <= 4'h3) || (addr[7:4] == 4'h9 && addr[3:0] >= 4'hA)
                      || (addr[7:4] == 4'h2 && (addr[3:0] == 4'h3 || addr[3:0] == 4'h8 || addr[3:0] == 4'h9));
  a_answer_next_cycle: assert property (take_w |=> ack) else $error("request not answered next cycle");
  a_ack_one_pulse: assert property (ack |=> !ack) else $error("answer stood longer than one cycle");
  a_ack_has_request: assert property (ack |-> $past(req)) else $error("answer without request");
  a_err_with_ack: assert property (err |-> ack) else $error("error outside an answer");
  a_absent_pad_err: assert property (take_w && cfg_w && gone_w |=> ack && err) else $error("absent pad accepted");
  a_bad_region_err: assert property (take_w && addr[9:8] == 2'h3 |=> err) else $error("unmapped region accepted");
  a_idle_rdata_zero: assert property (!ack |-> rdata == '0) else $error("read data outside an answer");
  a_err_rdata_zero: assert property (ack && err |-> rdata == '0) else $error("read data on an error");
  a_sel_upper_zero: assert property (ack && !we && addr[9:8] == 2'h1 |-> rdata[15:4] == '0)
    else $error("select read shows upper bits");
  a_link_write_clean: assert property (ack && we && cfg_w && wdata[7] |-> wdata[5:0] == '0)
    else $error("link write keeps enables");
  // Main scenarios reached.
  c_write: cover property (ack && we && !err);
  c_error: cover property (ack && err);
  c_sel_read: cover property (ack && !we && !err && addr[9:8] == 2'h1);
endmodule

/* File: pad_and_peripheral_input_mux_tb_top.sv */
// Self-checking bench joining the configuring master to the pad multiplexer.
// Assumes one 125 MHz clock and a synchronous active-high reset for both ends.
`timescale 1ns/1ps
module pad_and_peripheral_input_mux_tb_top;
  logic                                 clk_i, sys_rst_i, cmd_valid_i, cmd_write_i, t2_i, t4_i, t5_i, trace_i, adc_i;
  logic [pad_mux_pkg::NUM_PADS-1:0]     pad_in_i, gpio_out_i, alt1_out_i, pad_out_o, pad_oe_o, pad_ie_o, ana_o, link_o;
  logic [pad_mux_pkg::NUM_DEST:0]       dest_in_o;
  logic [9:0]                           cmd_addr_i;
  logic [15:0]                          cmd_wdata_i, rsp_rdata_o;
  logic                                 cmd_ready_o, rsp_valid_o, rsp_err_o;
  int                                   num_errors = 0, cmp_count = 0, cycles = 0;
  pad_mux_if bus_if ();
  pad_mux_device i_pad_mux_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if), .pad_in_i(pad_in_i),
    .gpio_out_i(gpio_out_i), .alt1_out_i(alt1_out_i), .timer_chan_two_out_i(t2_i), .timer_chan_four_out_i(t4_i),
    .timer_chan_five_out_i(t5_i), .trace_ready_n_i(trace_i), .adc_enable_i(adc_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .pad_ie_o(pad_ie_o), .analog_en_o(ana_o), .link_sel_o(link_o), .dest_in_o(dest_in_o));
  pad_mux_host i_pad_mux_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o), .rsp_rdata_o(rsp_rdata_o));
  pad_mux_sva i_pad_mux_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req(bus_if.req), .we(bus_if.we),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack), .err(bus_if.err), .rdata(bus_if.rdata));
  // Clock and hang guard.
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input string what, input logic [159:0] seen, input logic [159:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One command through the master, then its error flag and read data are judged.
  task automatic acc(input logic wr, input logic [9:0] a, input logic [15:0] d, input logic e, input logic [15:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_write_i <= wr;
    cmd_addr_i <= a;
    cmd_wdata_i <= d;
    #1;
    while (cmd_ready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1 n++;
    end
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    #1;
    while (rsp_valid_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n >= 50) num_errors++;
    chk("err", rsp_err_o, e);
    chk("rdata", rsp_rdata_o, r);
  endtask
  // Routes one pad to one destination, follows its level, then a reserved code cuts it.
  task automatic route(input logic [7:0] sreg, input logic [3:0] code, input logic [7:0] pad, input int dst);
    acc(1'b1, {2'h0, pad}, 16'h0020, 1'b0, 16'h0000);
    acc(1'b1, {2'h1, sreg}, {12'h000, code}, 1'b0, 16'h0000);
    acc(1'b0, {2'h1, sreg}, 16'h0000, 1'b0, {12'h000, code});
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_i);
      pad_in_i[pad] <= v[0];
      repeat (4) @(posedge clk_i);
      #1 chk("dest", dest_in_o[dst], v[0]);
    end
    @(posedge clk_i);
    pad_in_i[pad] <= 1'b1;
    acc(1'b1, {2'h1, sreg}, 16'h000F, 1'b0, 16'h0000);
    repeat (4) @(posedge clk_i);
    #1 chk("dest_reserved", dest_in_o[dst], 1'b0);
    acc(1'b1, {2'h1, sreg}, 16'h0000, 1'b0, 16'h0000);
    @(posedge clk_i);
    pad_in_i[pad] <= 1'b0;
  endtask
  // Walks codes 0 to 3 of J9 with both levels on its GPIO and ALT1 sources; trace_ready_n_i stays high.
  task automatic t_j9();
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 2; v++) begin
        @(posedge clk_i);
        gpio_out_i[pad_mux_pkg::PAD_J9] <= v[0];
        t5_i <= !v[0];
        acc(1'b1, 10'h099, {8'h00, 4'h3, 4'(c)}, 1'b0, 16'h0000);
        chk("j9_out", pad_out_o[153], c == 0 ? v[0] : c == 1 ? !v[0] : c == 2);
        chk("j9_oe", pad_oe_o[153], c < 3);
        chk("j9_ie", pad_ie_o[153], c < 3);
      end
    end
    // J8 codes 1 and 2 and a generic pad's code 1 must drive their own sources.
    @(posedge clk_i);
    t4_i <= 1'b1;
    alt1_out_i[0] <= 1'b1;
    acc(1'b1, 10'h098, 16'h0011, 1'b0, 16'h0000);
    chk("j8_alt1", pad_out_o[152], 1'b1);
    acc(1'b1, 10'h098, 16'h0012, 1'b0, 16'h0000);
    chk("j8_alt2", {pad_oe_o[152], pad_out_o[152]}, 2'b10);
    acc(1'b1, 10'h000, 16'h0011, 1'b0, 16'h0000);
    chk("a0_alt1", pad_out_o[0], 1'b1);
  endtask
  // Reset, absent places, link and analog paths, then seven routes from pads A15, B1, J8 and J9.
  initial begin
    {clk_i, cmd_valid_i, cmd_write_i, t2_i, t4_i, t5_i, adc_i} = '0;
    {pad_in_i, gpio_out_i, alt1_out_i, cmd_addr_i, cmd_wdata_i} = '0;
    trace_i = 1'b1;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk("oe_reset", pad_oe_o, '0);
    chk("dest_reset", dest_in_o, '0);
    acc(1'b0, 10'h099, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, 10'h1E5, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, 10'h037, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, 10'h023, 16'h0000, 1'b1, 16'h0000);
    acc(1'b1, 10'h070, 16'h0011, 1'b1, 16'h0000);
    acc(1'b0, 10'h09F, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, 10'h0A0, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, 10'h300, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, 10'h123, 16'h0000, 1'b1, 16'h0000);
    @(posedge clk_i);
    pad_in_i[159:144] <= 16'hFFFF;
    acc(1'b0, 10'h209, 16'h0000, 1'b0, 16'h03FF);
    @(posedge clk_i);
    pad_in_i[159:144] <= 16'h0000;
    t_j9();
    acc(1'b1, 10'h099, 16'h00B1, 1'b0, 16'h0000);
    chk("link_sel", {link_o[153], pad_oe_o[153], pad_ie_o[153], pad_out_o[153]}, 4'h8);
    acc(1'b0, 10'h099, 16'h0000, 1'b0, 16'h0080);
    acc(1'b1, 10'h099, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, 10'h095, 16'h0040, 1'b0, 16'h0000);
    chk("analog_off", ana_o[149], 1'b0);
    @(posedge clk_i);
    adc_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("analog_on", ana_o[149], 1'b1);
    route(pad_mux_pkg::SELREG_CAN0, 4'h1, pad_mux_pkg::PAD_A15, pad_mux_pkg::DEST_CAN0_RX);
    route(pad_mux_pkg::SELREG_CAN1, 4'h2, pad_mux_pkg::PAD_B1, pad_mux_pkg::DEST_CAN1_RX);
    route(pad_mux_pkg::SELREG_TRIG1, 4'h2, pad_mux_pkg::PAD_J9, pad_mux_pkg::DEST_TRIG1);
    route(pad_mux_pkg::SELREG_TMR5, 4'h4, pad_mux_pkg::PAD_J9, pad_mux_pkg::DEST_TIMER_FIVE);
    route(pad_mux_pkg::SELREG_MII3, 4'h1, pad_mux_pkg::PAD_J9, pad_mux_pkg::DEST_MII_BIT3);
    route(pad_mux_pkg::SELREG_TMR2, 4'h4, pad_mux_pkg::PAD_J8, pad_mux_pkg::DEST_TIMER_TWO);
    route(pad_mux_pkg::SELREG_TMR4, 4'h4, pad_mux_pkg::PAD_J8, pad_mux_pkg::DEST_TIMER_FOUR);
    give_verdict();
  end
endmodule
